// ### design/bcfw_frame_timer.sv
// Frame timer: loadable down-counter stepped once per microsecond.
// Assumes the load pulse and value come from the message sequencer.
`default_nettype none
module bcfw_frame_timer (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Reload from the sequencer
  input wire logic load,
  input wire logic [15:0] load_value,
  // Timer state
  output logic [15:0] count,
  output logic expire
);
  bcfw_pkg::bcfw_timer_s s_reg;
  bcfw_pkg::bcfw_timer_s s_next;

  // Divider, countdown and expiry pulse
  always_comb
  begin
    s_next = s_reg;
    s_next.expire = 1'b0;
    if (load)
    begin
      s_next.count = load_value;
      s_next.div = 8'h00;
    end
    else
    begin
      s_next.div = (s_reg.div == bcfw_pkg::TICK_LAST) ? 8'h00 : s_reg.div + 8'h01;
      // Holds at zero so one load yields one expiry
      if (s_reg.div == bcfw_pkg::TICK_LAST && s_reg.count != 16'h0000)
      begin
        s_next.count = s_reg.count - 16'h0001;
        s_next.expire = (s_reg.count == 16'h0001);
      end
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg <= '0;
      s_reg.count <= bcfw_pkg::RST_FRAME_COUNT;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign count = s_reg.count;
  assign expire = s_reg.expire;

  property p_timer_holds_zero;
    @(posedge aclk) disable iff (!aresetn)
    (s_reg.count == 16'h0000 && !load) |=> (s_reg.count == 16'h0000);
  endproperty
  a_timer_holds_zero: assert property (p_timer_holds_zero)
    else $error("frame timer left zero without a load");
endmodule
`default_nettype wire

// ### design/bcfw_pkg.sv
// Shared constants and state types for the frame watchdog / sync data block.
// Assumes a single 200 MHz clock and a synchronous active-low reset.
`default_nettype none
package bcfw_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_MASK = 8'h08;
  localparam logic [7:0] ADDR_FRAME_COUNT = 8'h0C;
  // Configuration field positions
  localparam int CFG_WATCHDOG_BIT = 4;
  localparam int CFG_SYNC_SRC_BIT = 3;
  localparam int CFG_EVEN_SYNC_BIT = 2;
  // Interrupt status / mask field positions
  localparam int INT_EOF_BIT = 0;
  // Control word bit that selects the time base as sync data
  localparam int CTRL_SEND_TIME_BIT = 15;
  // Reset values
  localparam logic RST_WATCHDOG = 1'b0;
  localparam logic RST_SYNC_SRC = 1'b0;
  localparam logic RST_EVEN_SYNC = 1'b0;
  localparam logic RST_EOF_MASK = 1'b0;
  localparam logic [15:0] RST_FRAME_COUNT = 16'h0000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Frame timer decrement period
  localparam int CLK_PERIOD_PS = 5000;
  localparam int FRAME_TICK_PS = 1000000;
  localparam int FRAME_TICK_CYCLES = FRAME_TICK_PS / CLK_PERIOD_PS;
  localparam logic [7:0] TICK_LAST = 8'(FRAME_TICK_CYCLES - 1);

  typedef struct packed {
    logic [15:0] count;
    logic [7:0] div;
    logic expire;
  } bcfw_timer_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic frame_watchdog_enable;
    logic sync_time_source_enable;
    logic even_sync_value;
    logic eof_status;
    logic eof_mask;
    logic irq;
    logic [15:0] mode_data;
    logic mode_valid;
    logic wr_en;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
  } bcfw_state_s;
endpackage
`default_nettype wire

// ### design/bcfw_top.sv
// Frame watchdog and sync-with-data source selection, with AXI4-Lite registers.
// Assumes the sequencer supplies message words and takes mode data back.
//
// How it works
// - With the watchdog and end-of-frame interrupt enabled, expiry of the frame timer sets EOF.
// - The sync source enable changes only the sync-with-data mode command data.
// - Sync enabled with control bit 15 low takes data from the message block at the pointer.
// - Sync enabled with control bit 15 high sends the low 16 bits of the time base.
// - A sent time base value is also written to the message block at the pointer.
// - Sync disabled always takes data from the message block whatever bit 15 is.
// - With even sync set, the sent time value has its LSB forced to zero.
// - With even sync clear, the time value goes out unchanged.
`default_nettype none
module bcfw_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Frame time reload from the sequencer
  input wire logic load_frame_time_op,
  input wire logic [15:0] frame_time_value,
  // Mode data request from the sequencer
  input wire logic mode_data_req,
  input wire logic sync_with_data_mode_cmd,
  input wire logic [15:0] ctrl_word,
  input wire logic [15:0] data_ptr,
  input wire logic [15:0] msg_data_word,
  input wire logic [31:0] time_base,
  // Mode data result
  output logic [15:0] mode_data,
  output logic mode_data_valid,
  // Write-back into the message data block
  output logic msg_wr_en,
  output logic [15:0] msg_wr_addr,
  output logic [15:0] msg_wr_data,
  // Interrupt
  output logic irq
);
  bcfw_pkg::bcfw_state_s s_reg;
  bcfw_pkg::bcfw_state_s s_next;
  logic [15:0] frame_count;
  logic frame_expire;
  logic send_time_in_sync_cmd;
  logic use_time;

  // Force the LSB low when even sync is requested
  function automatic logic [15:0] even_fix(input logic [15:0] value, input logic even);
    even_fix = even ? {value[15:1], 1'b0} : value;
  endfunction

  // Register address is mapped
  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr == bcfw_pkg::ADDR_CONFIG) || (addr == bcfw_pkg::ADDR_INT_STATUS) ||
                  (addr == bcfw_pkg::ADDR_INT_MASK) || (addr == bcfw_pkg::ADDR_FRAME_COUNT);
  endfunction

  // Frame timer, reloaded only by the sequencer's load step
  bcfw_frame_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(load_frame_time_op),
    .load_value(frame_time_value),
    .count(frame_count),
    .expire(frame_expire)
  );

  // Time base chosen only for the sync command with bit 15 set
  assign send_time_in_sync_cmd = ctrl_word[bcfw_pkg::CTRL_SEND_TIME_BIT];
  assign use_time = sync_with_data_mode_cmd && s_reg.sync_time_source_enable &&
                    send_time_in_sync_cmd;

  // Bus slave, configuration, interrupt and mode data next state
  always_comb
  begin
    logic clear_eof;
    logic [7:0] raddr;
    clear_eof = 1'b0;
    raddr = s_axi_araddr;
    s_next = s_reg;

    // Address and data may arrive in either order
    if (s_reg.awready && s_axi_awvalid)
    begin
      s_next.aw_got = 1'b1;
      s_next.waddr = s_axi_awaddr;
    end
    if (s_reg.wready && s_axi_wvalid)
    begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready)
    begin
      s_next.bvalid = 1'b0;
    end

    // Commit once both halves are held
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid)
    begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = addr_mapped(s_reg.waddr) ? bcfw_pkg::RESP_OKAY : bcfw_pkg::RESP_SLVERR;
      if (s_reg.wstrb[0])
      begin
        if (s_reg.waddr == bcfw_pkg::ADDR_CONFIG)
        begin
          s_next.frame_watchdog_enable = s_reg.wdata[bcfw_pkg::CFG_WATCHDOG_BIT];
          s_next.sync_time_source_enable = s_reg.wdata[bcfw_pkg::CFG_SYNC_SRC_BIT];
          s_next.even_sync_value = s_reg.wdata[bcfw_pkg::CFG_EVEN_SYNC_BIT];
        end
        if (s_reg.waddr == bcfw_pkg::ADDR_INT_MASK)
        begin
          s_next.eof_mask = s_reg.wdata[bcfw_pkg::INT_EOF_BIT];
        end
      end
    end
    // Ready only while a slot is free, so nothing is dropped
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready = !s_next.w_got && !s_next.bvalid;

    // Read: answer one cycle after the address is taken
    if (s_reg.rvalid && s_axi_rready)
    begin
      s_next.rvalid = 1'b0;
    end
    if (s_reg.arready && s_axi_arvalid)
    begin
      s_next.rvalid = 1'b1;
      s_next.rdata = 32'h0000_0000;
      s_next.rresp = addr_mapped(raddr) ? bcfw_pkg::RESP_OKAY : bcfw_pkg::RESP_SLVERR;
      unique case (raddr)
        bcfw_pkg::ADDR_CONFIG:
        begin
          s_next.rdata[bcfw_pkg::CFG_WATCHDOG_BIT] = s_reg.frame_watchdog_enable;
          s_next.rdata[bcfw_pkg::CFG_SYNC_SRC_BIT] = s_reg.sync_time_source_enable;
          s_next.rdata[bcfw_pkg::CFG_EVEN_SYNC_BIT] = s_reg.even_sync_value;
        end
        bcfw_pkg::ADDR_INT_STATUS:
        begin
          s_next.rdata[bcfw_pkg::INT_EOF_BIT] = s_reg.eof_status;
          clear_eof = 1'b1; // Read clears
        end
        bcfw_pkg::ADDR_INT_MASK:
        begin
          s_next.rdata[bcfw_pkg::INT_EOF_BIT] = s_reg.eof_mask;
        end
        bcfw_pkg::ADDR_FRAME_COUNT:
        begin
          s_next.rdata[15:0] = frame_count;
        end
        default:
        begin
          s_next.rdata = 32'h0000_0000;
        end
      endcase
    end
    s_next.arready = !s_next.rvalid;

    // End-of-frame pending; a new expiry wins over the read clear
    if (clear_eof)
    begin
      s_next.eof_status = 1'b0;
    end
    if (frame_expire && s_reg.frame_watchdog_enable && s_reg.eof_mask)
    begin
      s_next.eof_status = 1'b1;
    end
    s_next.irq = s_next.eof_status && s_next.eof_mask;

    // Mode data source selection, one-cycle result
    s_next.mode_valid = 1'b0;
    s_next.wr_en = 1'b0;
    if (mode_data_req)
    begin
      s_next.mode_valid = 1'b1;
      if (use_time)
      begin
        // Low half only, also for a 32-bit time base
        s_next.mode_data = even_fix(time_base[15:0], s_reg.even_sync_value);
        s_next.wr_en = 1'b1;
        s_next.wr_addr = data_ptr;
        s_next.wr_data = even_fix(time_base[15:0], s_reg.even_sync_value);
      end
      else
      begin
        s_next.mode_data = msg_data_word;
      end
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg <= '0;
      s_reg.frame_watchdog_enable <= bcfw_pkg::RST_WATCHDOG;
      s_reg.sync_time_source_enable <= bcfw_pkg::RST_SYNC_SRC;
      s_reg.even_sync_value <= bcfw_pkg::RST_EVEN_SYNC;
      s_reg.eof_mask <= bcfw_pkg::RST_EOF_MASK;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rdata = s_reg.rdata;
  assign mode_data = s_reg.mode_data;
  assign mode_data_valid = s_reg.mode_valid;
  assign msg_wr_en = s_reg.wr_en;
  assign msg_wr_addr = s_reg.wr_addr;
  assign msg_wr_data = s_reg.wr_data;
  assign irq = s_reg.irq;

  // Request kinds seen by the checks below
  sequence s_time_req;
    mode_data_req && sync_with_data_mode_cmd && s_reg.sync_time_source_enable &&
      ctrl_word[bcfw_pkg::CTRL_SEND_TIME_BIT];
  endsequence

  sequence s_mem_req;
    mode_data_req && !(sync_with_data_mode_cmd && s_reg.sync_time_source_enable &&
      ctrl_word[bcfw_pkg::CTRL_SEND_TIME_BIT]);
  endsequence

  property p_eof_set;
    @(posedge aclk) disable iff (!aresetn)
    (frame_expire && s_reg.frame_watchdog_enable && s_reg.eof_mask) |=>
      s_reg.eof_status && (irq == s_reg.eof_mask);
  endproperty
  a_eof_set: assert property (p_eof_set)
    else $error("end-of-frame pending not raised on expiry");

  property p_eof_cause;
    @(posedge aclk) disable iff (!aresetn)
    $rose(s_reg.eof_status) |-> $past(frame_expire && s_reg.frame_watchdog_enable);
  endproperty
  a_eof_cause: assert property (p_eof_cause)
    else $error("end-of-frame pending raised without enabled expiry");

  property p_mem_data;
    @(posedge aclk) disable iff (!aresetn)
    s_mem_req |=> mode_data_valid && (mode_data == $past(msg_data_word));
  endproperty
  a_mem_data: assert property (p_mem_data)
    else $error("sync data not taken from message block");

  property p_time_plain;
    @(posedge aclk) disable iff (!aresetn)
    (s_time_req and (!s_reg.even_sync_value)) |=> (mode_data == $past(time_base[15:0]));
  endproperty
  a_time_plain: assert property (p_time_plain)
    else $error("time base not sent unchanged");

  property p_time_even;
    @(posedge aclk) disable iff (!aresetn)
    (s_time_req and s_reg.even_sync_value) |=>
      (mode_data[0] == 1'b0) && (mode_data[15:1] == $past(time_base[15:1]));
  endproperty
  a_time_even: assert property (p_time_even)
    else $error("even sync value has LSB set");

  property p_write_back;
    @(posedge aclk) disable iff (!aresetn)
    s_time_req |=> msg_wr_en && (msg_wr_addr == $past(data_ptr)) && (msg_wr_data == mode_data);
  endproperty
  a_write_back: assert property (p_write_back)
    else $error("sent time value not written back");

  property p_no_write_back;
    @(posedge aclk) disable iff (!aresetn)
    (s_mem_req or (!mode_data_req)) |=> !msg_wr_en;
  endproperty
  a_no_write_back: assert property (p_no_write_back)
    else $error("unexpected message block write");

  property p_irq_level;
    @(posedge aclk) disable iff (!aresetn)
    (s_reg.eof_status && s_reg.eof_mask) [*2] |-> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt low with unmasked pending bit");

  // Source selection and pending-bit guards
  property p_plain_msg;
    @(posedge aclk) disable iff (!aresetn)
    (mode_data_req && !sync_with_data_mode_cmd) |=> (mode_data == $past(msg_data_word));
  endproperty
  a_plain_msg: assert property (p_plain_msg)
    else $error("non-sync message data not taken from message block");

  property p_sync_off;
    @(posedge aclk) disable iff (!aresetn)
    (mode_data_req && !s_reg.sync_time_source_enable) |=> (mode_data == $past(msg_data_word));
  endproperty
  a_sync_off: assert property (p_sync_off)
    else $error("sync source disabled but data not from message block");

  property p_bit15_low;
    @(posedge aclk) disable iff (!aresetn)
    (mode_data_req && !ctrl_word[bcfw_pkg::CTRL_SEND_TIME_BIT]) |=> !msg_wr_en &&
      (mode_data == $past(msg_data_word));
  endproperty
  a_bit15_low: assert property (p_bit15_low)
    else $error("control bit 15 low but data not from message block");

  property p_eof_needs_watchdog;
    @(posedge aclk) disable iff (!aresetn)
    (!s_reg.frame_watchdog_enable && !s_reg.eof_status) |=> !s_reg.eof_status;
  endproperty
  a_eof_needs_watchdog: assert property (p_eof_needs_watchdog)
    else $error("end-of-frame pending raised with watchdog disabled");

  property p_eof_needs_mask;
    @(posedge aclk) disable iff (!aresetn)
    (!s_reg.eof_mask && !s_reg.eof_status) |=> !s_reg.eof_status;
  endproperty
  a_eof_needs_mask: assert property (p_eof_needs_mask)
    else $error("end-of-frame pending raised with interrupt disabled");

  property p_eof_sticky;
    @(posedge aclk) disable iff (!aresetn)
    (s_reg.eof_status && !(s_axi_arvalid && s_axi_arready)) |=> s_reg.eof_status;
  endproperty
  a_eof_sticky: assert property (p_eof_sticky)
    else $error("end-of-frame pending lost without a read");
endmodule
`default_nettype wire

// ### tb/bcfw_seq_model.sv
// Behavioural message sequencer: message RAM, frame time reloads and mode data requests.
// Assumes the bench calls its tasks from one process, in the aclk domain.
`default_nettype none
module bcfw_seq_model (
  // Clock
  input wire logic aclk,
  // Towards the block
  output logic load_frame_time_op,
  output logic [15:0] frame_time_value,
  output logic mode_data_req,
  output logic sync_with_data_mode_cmd,
  output logic [15:0] ctrl_word,
  output logic [15:0] data_ptr,
  output logic [15:0] msg_data_word,
  output logic [31:0] time_base,
  // Write-back into the message RAM
  input wire logic msg_wr_en,
  input wire logic [15:0] msg_wr_addr,
  input wire logic [15:0] msg_wr_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [16];

  // Odd time base so that forcing the low bit is visible
  initial
  begin
    load_frame_time_op = 1'b0;
    frame_time_value = 16'h0000;
    mode_data_req = 1'b0;
    sync_with_data_mode_cmd = 1'b0;
    ctrl_word = 16'h0000;
    data_ptr = 16'h0000;
    time_base = 32'hC3D2B5A7;
    for (int i = 0; i < 16; i++)
      mem[i] = 16'h3C00 + 16'(i * 257);
  end

  // Small RAM: only the low pointer bits decode
  assign msg_data_word = mem[data_ptr[3:0]];
  always @(posedge aclk)
    if (msg_wr_en)
      mem[msg_wr_addr[3:0]] <= msg_wr_data;

  // Reload value chosen by the caller to cover the whole frame
  task automatic load(input logic [15:0] v);
    @(posedge aclk);
    load_frame_time_op <= 1'b1;
    frame_time_value <= v;
    @(posedge aclk);
    load_frame_time_op <= 1'b0;
    frame_time_value <= ~v;
  endtask

  // One-cycle request; qualifiers scrambled afterwards, pointer kept for write-back
  task automatic request(input logic cmd, input logic [15:0] ctrl, input logic [15:0] ptr);
    @(posedge aclk);
    mode_data_req <= 1'b1;
    sync_with_data_mode_cmd <= cmd;
    ctrl_word <= ctrl;
    data_ptr <= ptr;
    @(posedge aclk);
    mode_data_req <= 1'b0;
    sync_with_data_mode_cmd <= ~cmd;
    ctrl_word <= ~ctrl;
  endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench: AXI4-Lite register tasks plus sequencer model calls.
// Assumes bcfw_top and bcfw_seq_model are compiled before it.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic load_op, req, cmd_w, msg_wr_en;
  wire logic [15:0] ftv, ctrl, ptr, mword, mode_data, wr_addr, wr_data;
  wire logic [31:0] tbase;
  logic mode_data_valid, irq;
  int num_errors = 0;
  int total_checks = 0;

  bcfw_top u_bcfw_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .load_frame_time_op(load_op), .frame_time_value(ftv),
    .mode_data_req(req), .sync_with_data_mode_cmd(cmd_w), .ctrl_word(ctrl), .data_ptr(ptr),
    .msg_data_word(mword), .time_base(tbase), .mode_data(mode_data),
    .mode_data_valid(mode_data_valid), .msg_wr_en(msg_wr_en), .msg_wr_addr(wr_addr),
    .msg_wr_data(wr_data), .irq(irq));

  bcfw_seq_model u_bcfw_seq_model (.aclk(aclk), .load_frame_time_op(load_op),
    .frame_time_value(ftv), .mode_data_req(req), .sync_with_data_mode_cmd(cmd_w),
    .ctrl_word(ctrl), .data_ptr(ptr), .msg_data_word(mword), .time_base(tbase),
    .msg_wr_en(msg_wr_en), .msg_wr_addr(wr_addr), .msg_wr_data(wr_data));

  // 200 MHz clock
  initial
    aclk = 1'b0;
  always #2.5 aclk = ~aclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic summarize();
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // A wait that ran out ends the run at once
  task automatic give_up();
    chk(32'h0, 32'h1, "wait ran out");
    summarize();
  endtask

  // Address and data offered together, each released once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    while (n < 200)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1)
      give_up();
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    while (n < 200)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1)
      give_up();
  endtask

  // Main sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] exp, old;
    logic ev, sy, b15, cmd, ts;
    int n;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, then an unmapped place
    for (int a = 0; a < 4; a++)
    begin
      axi_read(8'(a * 4), d, r);
      chk(d, 32'h0, "reset value");
      chk(32'(r), 32'(bcfw_pkg::RESP_OKAY), "read resp");
    end
    axi_read(8'h10, d, r);
    chk(32'(r), 32'(bcfw_pkg::RESP_SLVERR), "unmapped read resp");
    axi_write(8'h14, 32'hFFFFFFFF, r);
    chk(32'(r), 32'(bcfw_pkg::RESP_SLVERR), "unmapped write resp");
    // Every mix of even, source enable, bit 15 and command kind
    for (int k = 0; k < 16; k++)
    begin
      ev = k[3];
      sy = k[2];
      b15 = k[1];
      cmd = k[0];
      axi_write(bcfw_pkg::ADDR_CONFIG, {28'h0, sy, ev, 2'h0}, r);
      axi_read(bcfw_pkg::ADDR_CONFIG, d, r);
      chk(d, {28'h0, sy, ev, 2'h0}, "config readback");
      old = u_bcfw_seq_model.mem[k];
      ts = cmd & sy & b15;
      exp = ts ? {tbase[15:1], tbase[0] & ~ev} : old;
      u_bcfw_seq_model.request(cmd, {b15, 15'h1234}, 16'(k));
      @(posedge aclk);
      chk(32'(mode_data_valid), 32'h1, "mode data valid");
      chk(32'(mode_data), 32'(exp), "mode data");
      chk(32'(msg_wr_en), 32'(ts), "write-back strobe");
      if (ts)
        chk({wr_addr, wr_data}, {16'(k), exp}, "write-back");
      @(posedge aclk);
      chk(32'(mode_data_valid), 32'h0, "valid one cycle");
      chk(32'(u_bcfw_seq_model.mem[k]), 32'(exp), "message RAM");
    end
    // A write with the low strobe off changes nothing
    s_axi_wstrb <= 4'hE;
    axi_write(bcfw_pkg::ADDR_CONFIG, 32'h0, r);
    s_axi_wstrb <= 4'hF;
    chk(32'(r), 32'(bcfw_pkg::RESP_OKAY), "masked write resp");
    axi_read(bcfw_pkg::ADDR_CONFIG, d, r);
    chk(d, 32'hC, "strobe-masked write ignored");
    // Watchdog enabled and interrupt enabled: one event per load
    axi_write(bcfw_pkg::ADDR_INT_MASK, 32'h1, r);
    axi_write(bcfw_pkg::ADDR_CONFIG, 32'h10, r);
    u_bcfw_seq_model.load(16'h0002);
    axi_read(bcfw_pkg::ADDR_FRAME_COUNT, d, r);
    chk(d, 32'h2, "frame count loaded");
    n = 0;
    while (irq !== 1'b1 && n < 1000)
    begin
      @(posedge aclk);
      n++;
    end
    chk(32'(n >= 370 && n <= 420), 32'h1, "expiry time");
    if (n >= 1000)
      give_up();
    axi_read(bcfw_pkg::ADDR_INT_STATUS, d, r);
    chk(d, 32'h1, "end of frame status");
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h0, "irq after clearing read");
    repeat (500) @(posedge aclk);
    axi_read(bcfw_pkg::ADDR_INT_STATUS, d, r);
    chk(d, 32'h0, "no second event");
    axi_read(bcfw_pkg::ADDR_FRAME_COUNT, d, r);
    chk(d, 32'h0, "timer parked at zero");
    // Watchdog off, then interrupt enable off: no event
    for (int j = 0; j < 2; j++)
    begin
      axi_write(bcfw_pkg::ADDR_CONFIG, j ? 32'h10 : 32'h0, r);
      axi_write(bcfw_pkg::ADDR_INT_MASK, j ? 32'h0 : 32'h1, r);
      u_bcfw_seq_model.load(16'h0001);
      repeat (300) @(posedge aclk);
      chk(32'(irq), 32'h0, "irq stays low");
      axi_read(bcfw_pkg::ADDR_INT_STATUS, d, r);
      chk(d, 32'h0, "status stays clear");
    end
    summarize();
  end
endmodule
`default_nettype wire
